// >>> ssc_regs.sv
`timescale 1ns/100ps

module ssc_regs
(
  // clock, reset, enable
  input  wire  logic       mclk,
  input  wire  logic       rst,
  input  wire  logic       clk_en,
  // register access from the serial port engine
  input  wire  logic       reg_wr,
  input  wire  logic       reg_rd,
  input  wire  logic [6:0] reg_addr,
  input  wire  logic [7:0] reg_wdata,
  output logic       [7:0] reg_rdata,
  // link events
  input  wire  logic       link_byte_valid,
  input  wire  logic [7:0] link_byte,
  input  wire  logic       conv_done,
  input  wire  logic       result_low_byte_read,
  // general pins
  input  wire  logic [6:0] general_pin_in,
  input  wire  logic [6:0] general_pin_data,
  output logic       [6:0] general_pin_out,
  output logic       [6:0] general_pin_oe,
  output logic       [6:0] general_pin_sampled,
  // data-ready and configuration
  output logic             ready_n,
  output logic             stream_kind_select,
  output logic       [6:0] controlled_stream_span,
  output logic       [6:0] short_read_start,
  output logic       [2:0] short_read_length,
  output logic             gain_background_correction,
  output logic             checksum_enable,
  output logic             ready_release_after_checksum
);
  import ssc_pkg::*;

  function automatic logic [7:0] checksum_step(
    input logic [7:0] acc,
    input logic [7:0] data
  );
    logic [7:0] c;
    c = acc ^ data;
    for (int i = 0; i < 8; i++)
      c = c[7] ? ((c << 1) ^ CHECKSUM_POLY) : (c << 1);
    return c;
  endfunction : checksum_step

  // configuration registers
  logic       ready_on_pin_six;
  logic       checksum_keep;
  logic [2:0] ready_keep_bits;
  logic       checksum_keep1;
  logic [6:0] pin_direction_bit;

  logic       next_stream_kind_select;
  logic [6:0] next_controlled_stream_span;
  logic [6:0] next_short_read_start;
  logic [2:0] next_short_read_length;
  logic       next_ready_on_pin_six;
  logic       next_checksum_keep;
  logic       next_gain_background_correction;
  logic [2:0] next_ready_keep_bits;
  logic       next_checksum_enable;
  logic       next_checksum_keep1;
  logic       next_ready_release_after_checksum;
  logic [6:0] next_pin_direction_bit;

  wire        wr_stream  = reg_wr && (reg_addr == ADDR_STREAM_CONTROL);
  wire        wr_start   = reg_wr && (reg_addr == ADDR_SHORT_READ_START);
  wire        wr_len     = reg_wr && (reg_addr == ADDR_SHORT_READ_LEN);
  wire        wr_dir     = reg_wr && (reg_addr == ADDR_PIN_DIRECTION);
  wire        wr_ready   = reg_wr && (reg_addr == ADDR_READY_CONTROL);
  wire        wr_sum_ctl = reg_wr && (reg_addr == ADDR_CHECKSUM_CONTROL);
  wire        wr_sum_val = reg_wr && (reg_addr == ADDR_CHECKSUM_VALUE);
  wire        rd_sum_val = reg_rd && (reg_addr == ADDR_CHECKSUM_VALUE);

  always_comb
  begin
    next_stream_kind_select           = stream_kind_select;
    next_controlled_stream_span       = controlled_stream_span;
    next_short_read_start             = short_read_start;
    next_short_read_length            = short_read_length;
    next_ready_on_pin_six             = ready_on_pin_six;
    next_checksum_keep                = checksum_keep;
    next_gain_background_correction   = gain_background_correction;
    next_ready_keep_bits              = ready_keep_bits;
    next_checksum_enable              = checksum_enable;
    next_checksum_keep1               = checksum_keep1;
    next_ready_release_after_checksum = ready_release_after_checksum;
    next_pin_direction_bit            = pin_direction_bit;
    if (wr_stream)
    begin
      next_stream_kind_select     = reg_wdata[STREAM_KIND_BIT];
      next_controlled_stream_span = reg_wdata[6:0];
    end
    if (wr_start)
      next_short_read_start = reg_wdata[6:0];
    if (wr_len)
      next_short_read_length = reg_wdata[2:0];
    if (wr_dir)
      next_pin_direction_bit = reg_wdata[6:0];
    if (wr_ready)
    begin
      next_ready_on_pin_six           = reg_wdata[READY_ON_PIN_BIT];
      next_checksum_keep              = reg_wdata[CHECKSUM_KEEP_BIT];
      next_gain_background_correction = reg_wdata[GAIN_BG_BIT];
      next_ready_keep_bits            = reg_wdata[2:0];
    end
    if (wr_sum_ctl)
    begin
      next_checksum_enable              = reg_wdata[CHECKSUM_ENABLE_BIT];
      next_checksum_keep1               = reg_wdata[CHECKSUM_KEEP1_BIT];
      next_ready_release_after_checksum = reg_wdata[RELEASE_AFTER_BIT];
    end
  end

  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      stream_kind_select           <= RST_STREAM_CONTROL[STREAM_KIND_BIT];
      controlled_stream_span       <= RST_STREAM_CONTROL[6:0];
      short_read_start             <= RST_SHORT_READ_START;
      short_read_length            <= RST_SHORT_READ_LEN;
      ready_on_pin_six             <= 1'b0;
      checksum_keep                <= 1'b0;
      gain_background_correction   <= 1'b0;
      ready_keep_bits              <= RST_READY_KEEP_BITS;
      checksum_enable              <= 1'b0;
      checksum_keep1               <= RST_CHECKSUM_KEEP1;
      ready_release_after_checksum <= 1'b0;
      pin_direction_bit            <= RST_PIN_DIRECTION;
    end
    else if (clk_en)
    begin
      stream_kind_select           <= next_stream_kind_select;
      controlled_stream_span       <= next_controlled_stream_span;
      short_read_start             <= next_short_read_start;
      short_read_length            <= next_short_read_length;
      ready_on_pin_six             <= next_ready_on_pin_six;
      checksum_keep                <= next_checksum_keep;
      // direct mode only useful in some scan modes; not enforced here
      gain_background_correction   <= next_gain_background_correction;
      ready_keep_bits              <= next_ready_keep_bits;
      checksum_enable              <= next_checksum_enable;
      checksum_keep1               <= next_checksum_keep1;
      ready_release_after_checksum <= next_ready_release_after_checksum;
      pin_direction_bit            <= next_pin_direction_bit;
    end
  end

  // data-ready sequencing and checksum accumulator
  ssc_ready_e ready_state;
  ssc_ready_e next_ready_state;
  logic       next_ready_n;
  logic [7:0] checksum_acc;
  logic [7:0] next_checksum_acc;
  logic       release_evt;
  logic [7:0] sum_base;

  always_comb
  begin
    next_ready_state = ready_state;
    release_evt      = 1'b0;
    case (ready_state)
      SSC_READY_ASSERTED:
      begin
        if (result_low_byte_read)
        begin
          if (ready_release_after_checksum)
            next_ready_state = SSC_READY_WAIT_SUM;
          else
            release_evt = 1'b1;
        end
      end
      SSC_READY_WAIT_SUM:
        release_evt = rd_sum_val;
      default:
        next_ready_state = SSC_READY_IDLE;
    endcase
    if (release_evt)
      next_ready_state = SSC_READY_IDLE;
    // a new result wins over a release in the same cycle
    if (conv_done)
    begin
      next_ready_state = SSC_READY_ASSERTED;
      release_evt      = 1'b0;
    end
    next_ready_n = (next_ready_state == SSC_READY_IDLE);

    if (wr_sum_val || (release_evt && !checksum_keep))
      sum_base = RST_CHECKSUM;
    else
      sum_base = checksum_acc;
    if (checksum_enable && link_byte_valid)
      next_checksum_acc = checksum_step(sum_base, link_byte);
    else
      next_checksum_acc = sum_base;
  end

  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      ready_state  <= SSC_READY_IDLE;
      ready_n      <= 1'b1;
      checksum_acc <= RST_CHECKSUM;
    end
    else if (clk_en)
    begin
      ready_state  <= next_ready_state;
      ready_n      <= next_ready_n;
      checksum_acc <= next_checksum_acc;
    end
  end

  // read mux
  logic [7:0] next_reg_rdata;

  always_comb
  begin
    next_reg_rdata = reg_rdata;
    if (reg_rd)
    begin
      case (reg_addr)
        ADDR_STREAM_CONTROL:
          next_reg_rdata = {stream_kind_select, controlled_stream_span};
        ADDR_SHORT_READ_START:
          next_reg_rdata = {1'b0, short_read_start};
        ADDR_SHORT_READ_LEN:
          next_reg_rdata = {5'h00, short_read_length};
        ADDR_PIN_DIRECTION:
          next_reg_rdata = {1'b0, pin_direction_bit};
        ADDR_READY_CONTROL:
          next_reg_rdata = {ready_on_pin_six, 1'b0, checksum_keep, 1'b0,
                            gain_background_correction, ready_keep_bits};
        ADDR_CHECKSUM_CONTROL:
          next_reg_rdata = {3'h0, checksum_enable, checksum_keep1,
                            ready_release_after_checksum, 2'h0};
        ADDR_CHECKSUM_VALUE:
          next_reg_rdata = checksum_acc;
        default:
          next_reg_rdata = UNMAPPED_READ;
      endcase
    end
  end

  always_ff @(posedge mclk)
  begin
    if (rst)
      reg_rdata <= UNMAPPED_READ;
    else if (clk_en)
      reg_rdata <= next_reg_rdata;
  end

  // general pins: input filter and output drive, one slice per pin
  logic [6:0] pin_s1;
  logic [6:0] pin_s2;
  logic [6:0] pin_s3;
  logic [6:0] next_pin_sampled;
  logic [6:0] next_pin_out;
  logic [6:0] next_pin_oe;

  for (genvar n = 0; n < PIN_COUNT; n++)
  begin : g_pin
    always_comb
    begin
      // a change counts only when the last two stages agree
      next_pin_sampled[n] = (pin_s2[n] == pin_s3[n]) ? pin_s3[n]
                                                     : general_pin_sampled[n];
      next_pin_out[n] = general_pin_data[n];
      next_pin_oe[n]  = next_pin_direction_bit[n];
      if ((n == READY_PIN_INDEX) && next_ready_on_pin_six)
      begin
        next_pin_out[n] = next_ready_n;
        next_pin_oe[n]  = 1'b1;
      end
    end
  end

  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      pin_s1              <= 7'h00;
      pin_s2              <= 7'h00;
      pin_s3              <= 7'h00;
      general_pin_sampled <= 7'h00;
      general_pin_out     <= 7'h00;
      general_pin_oe      <= 7'h00;
    end
    else if (clk_en)
    begin
      pin_s1              <= general_pin_in;
      pin_s2              <= pin_s1;
      pin_s3              <= pin_s2;
      general_pin_sampled <= next_pin_sampled;
      general_pin_out     <= next_pin_out;
      general_pin_oe      <= next_pin_oe;
    end
  end

endmodule : ssc_regs

// >>> ssc_pkg.sv
package ssc_pkg;

  // register addresses on the serial host port
  localparam logic [6:0] ADDR_STREAM_CONTROL   = 7'h03;
  localparam logic [6:0] ADDR_SHORT_READ_START = 7'h09;
  localparam logic [6:0] ADDR_SHORT_READ_LEN   = 7'h0a;
  localparam logic [6:0] ADDR_PIN_DIRECTION    = 7'h0e;
  localparam logic [6:0] ADDR_READY_CONTROL    = 7'h11;
  localparam logic [6:0] ADDR_CHECKSUM_CONTROL = 7'h13;
  localparam logic [6:0] ADDR_CHECKSUM_VALUE   = 7'h1d;

  // field positions
  localparam int STREAM_KIND_BIT     = 7;
  localparam int READY_ON_PIN_BIT    = 7;
  localparam int CHECKSUM_KEEP_BIT   = 5;
  localparam int GAIN_BG_BIT         = 3;
  localparam int CHECKSUM_ENABLE_BIT = 4;
  localparam int CHECKSUM_KEEP1_BIT  = 3;
  localparam int RELEASE_AFTER_BIT   = 2;
  localparam int READY_PIN_INDEX     = 6;
  localparam int PIN_COUNT           = 7;

  // reset values
  localparam logic [7:0] RST_STREAM_CONTROL   = 8'h00;
  localparam logic [6:0] RST_SHORT_READ_START = 7'h1a;
  localparam logic [2:0] RST_SHORT_READ_LEN   = 3'h2;
  localparam logic [6:0] RST_PIN_DIRECTION    = 7'h00;
  localparam logic [2:0] RST_READY_KEEP_BITS  = 3'h3;
  localparam logic       RST_CHECKSUM_KEEP1   = 1'b1;
  localparam logic [7:0] RST_CHECKSUM         = 8'h00;

  // checksum generator polynomial, x^8 + x^2 + x + 1
  localparam logic [7:0] CHECKSUM_POLY        = 8'h07;
  localparam logic [7:0] UNMAPPED_READ        = 8'h00;

  typedef enum logic [1:0] {
    SSC_READY_IDLE     = 2'b00,
    SSC_READY_ASSERTED = 2'b01,
    SSC_READY_WAIT_SUM = 2'b10
  } ssc_ready_e;

endpackage : ssc_pkg

// >>> ssc_host_model.sv
`timescale 1ns/100ps

module ssc_host_model
  import ssc_pkg::*;
(
  // clock and read-back
  input  wire  logic       mclk,
  input  wire  logic [7:0] reg_rdata,
  // register strobes
  output logic             reg_wr,
  output logic             reg_rd,
  output logic       [6:0] reg_addr,
  output logic       [7:0] reg_wdata,
  // link events
  output logic             link_byte_valid,
  output logic       [7:0] link_byte,
  output logic             conv_done,
  output logic             result_low_byte_read
);
  initial
  begin
    {reg_wr, reg_rd, link_byte_valid, conv_done} = 4'h0;
    result_low_byte_read = 1'b0;
    reg_addr = 7'h7f;
    reg_wdata = 8'h00;
    link_byte = 8'h00;
  end

  task automatic put(input logic [6:0] a, input logic [7:0] d);
    logic [7:0] v;
    v = d;
    if (a == ADDR_READY_CONTROL)
      v[2:0] = 3'h3;
    if (a == ADDR_CHECKSUM_CONTROL)
      v[3] = 1'b1;
    @(posedge mclk);
    #1;
    reg_addr = a;
    reg_wdata = v;
    reg_wr = 1'b1;
    @(posedge mclk);
    #1;
    reg_wr = 1'b0;
    // stale data must not look held
    reg_wdata = ~v;
  endtask : put

  task automatic get(input logic [6:0] a, output logic [7:0] q);
    @(posedge mclk);
    #1;
    reg_addr = a;
    reg_rd = 1'b1;
    @(posedge mclk);
    #1;
    reg_rd = 1'b0;
    @(posedge mclk);
    #1;
    q = reg_rdata;
  endtask : get

  // kind 0 conversion, 1 low byte read, 2 link byte
  task automatic ev(input int k, input logic [7:0] b);
    @(posedge mclk);
    #1;
    link_byte = b;
    conv_done = (k == 0);
    result_low_byte_read = (k == 1);
    link_byte_valid = (k == 2);
    @(posedge mclk);
    #1;
    {conv_done, result_low_byte_read, link_byte_valid} = 3'h0;
    link_byte = ~b;
  endtask : ev
endmodule : ssc_host_model

// >>> ssc_regs_asserts.sv
`timescale 1ns/100ps

module ssc_regs_chk
  import ssc_pkg::*;
(
  // clock and register port
  input wire logic       mclk,
  input wire logic       rst,
  input wire logic       clk_en,
  input wire logic       reg_wr,
  input wire logic       reg_rd,
  input wire logic [6:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata,
  // events and levels
  input wire logic       conv_done,
  input wire logic       result_low_byte_read,
  input wire logic [6:0] general_pin_out,
  input wire logic [6:0] general_pin_oe,
  input wire logic       ready_n,
  input wire logic       stream_kind_select,
  input wire logic [6:0] controlled_stream_span,
  input wire logic [6:0] short_read_start,
  input wire logic [2:0] short_read_length,
  input wire logic       gain_background_correction,
  input wire logic       checksum_enable,
  input wire logic       ready_release_after_checksum
);
  logic route;
  logic next_route;
  logic wr_ok;
  logic rls;

  assign wr_ok = clk_en && reg_wr;
  assign rls = clk_en && result_low_byte_read && !ready_n && !conv_done;

  // shadow of the routing bit, not visible at the ports
  always_comb
  begin
    next_route = route;
    if (wr_ok && reg_addr == ADDR_READY_CONTROL)
      next_route = reg_wdata[READY_ON_PIN_BIT];
    if (rst)
      next_route = 1'b0;
  end

  always_ff @(posedge mclk)
    route <= next_route;

  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (rst);

  chk_ready_set : assert property (
    clk_en && conv_done |=> !ready_n)
    else $error("data-ready not asserted");
  chk_release_direct : assert property (
    rls && !ready_release_after_checksum |=> ready_n)
    else $error("data-ready not released");
  chk_release_waits : assert property (
    rls && ready_release_after_checksum &&
    !(reg_rd && reg_addr == ADDR_CHECKSUM_VALUE) |=> !ready_n)
    else $error("data-ready released early");
  chk_pin_route : assert property (
    route |-> general_pin_oe[6] && general_pin_out[6] == ready_n)
    else $error("pin six not carrying data-ready");
  chk_stream_write : assert property (
    wr_ok && reg_addr == ADDR_STREAM_CONTROL |=>
    {stream_kind_select, controlled_stream_span} == $past(reg_wdata))
    else $error("stream fields not updated");
  chk_start_write : assert property (
    wr_ok && reg_addr == ADDR_SHORT_READ_START |=>
    short_read_start == $past(reg_wdata[6:0]))
    else $error("start address not updated");
  chk_length_write : assert property (
    wr_ok && reg_addr == ADDR_SHORT_READ_LEN |=>
    short_read_length == $past(reg_wdata[2:0]))
    else $error("length not updated");
  chk_sum_control : assert property (
    wr_ok && reg_addr == ADDR_CHECKSUM_CONTROL |=>
    checksum_enable == $past(reg_wdata[4]) &&
    ready_release_after_checksum == $past(reg_wdata[2]))
    else $error("checksum control not updated");
  chk_gain_write : assert property (
    wr_ok && reg_addr == ADDR_READY_CONTROL |=>
    gain_background_correction == $past(reg_wdata[3]))
    else $error("gain bit not updated");
  chk_unmapped_zero : assert property (
    clk_en && reg_rd && reg_addr > 7'h1d |=> reg_rdata == 8'h00)
    else $error("unmapped read not zero");
endmodule : ssc_regs_chk

// >>> test_spi_stream_crc_gpio_ctrl.sv
`timescale 1ns/100ps

module test_spi_stream_crc_gpio_ctrl;
  import ssc_pkg::*;
  logic       mclk = 1'b0;
  logic       rst = 1'b1;
  logic       clk_en = 1'b1;
  logic       reg_wr, reg_rd, link_byte_valid, conv_done;
  logic       result_low_byte_read, ready_n, stream_kind_select;
  logic       gain_background_correction, checksum_enable;
  logic       ready_release_after_checksum;
  logic [6:0] reg_addr, general_pin_in, general_pin_data, general_pin_out;
  logic [6:0] general_pin_oe, general_pin_sampled, controlled_stream_span;
  logic [6:0] short_read_start;
  logic [2:0] short_read_length;
  logic [7:0] reg_wdata, reg_rdata, link_byte, q, b, sum_m;
  int         miscompares = 0;
  int         comparisons = 0;
  int         seed = 43814;
  logic [6:0] adr [7] = '{7'h03, 7'h09, 7'h0a, 7'h0e, 7'h11, 7'h13, 7'h1d};
  logic [7:0] mdl [7] = '{8'h00, 8'h1a, 8'h02, 8'h00, 8'h03, 8'h08, 8'h00};
  logic [7:0] msk [7] = '{8'hff, 8'h7f, 8'h07, 8'h7f, 8'haf, 8'h1c, 8'h00};

  always #4 mclk = ~mclk;

  ssc_regs dut_u (.mclk, .rst, .clk_en, .reg_wr, .reg_rd, .reg_addr,
    .reg_wdata, .reg_rdata, .link_byte_valid, .link_byte, .conv_done,
    .result_low_byte_read, .general_pin_in, .general_pin_data,
    .general_pin_out, .general_pin_oe, .general_pin_sampled, .ready_n,
    .stream_kind_select, .controlled_stream_span, .short_read_start,
    .short_read_length, .gain_background_correction, .checksum_enable,
    .ready_release_after_checksum);
  ssc_host_model host_u (.mclk, .reg_rdata, .reg_wr, .reg_rd, .reg_addr,
    .reg_wdata, .link_byte_valid, .link_byte, .conv_done,
    .result_low_byte_read);

  task automatic cmp_rd(input logic [7:0] got, input logic [7:0] want);
    comparisons++;
    if (got !== want)
    begin
      miscompares++;
      $display("[FAIL] %0t read %h expected %h", $time, got, want);
    end
  endtask : cmp_rd

  task automatic cmp_lvl(input logic [6:0] got, input logic [6:0] want);
    comparisons++;
    if (got !== want)
    begin
      miscompares++;
      $display("[FAIL] %0t level %h expected %h", $time, got, want);
    end
  endtask : cmp_lvl

  task automatic rd_chk(input int i);
    host_u.get(adr[i], q);
    cmp_rd(q, (i == 6) ? sum_m : mdl[i]);
  endtask : rd_chk

  task automatic wr_m(input int i, input logic [7:0] d);
    host_u.put(adr[i], d);
    mdl[i] = d & msk[i];
    mdl[4][2:0] = 3'h3;
    mdl[5][3] = 1'b1;
    if (i == 6)
      sum_m = 8'h00;
  endtask : wr_m

  function automatic logic [7:0] sum_step(input logic [7:0] c, d);
    logic [7:0] r;
    r = c ^ d;
    for (int k = 0; k < 8; k++)
      r = r[7] ? {r[6:0], 1'b0} ^ 8'h07 : {r[6:0], 1'b0};
    return r;
  endfunction : sum_step

  task automatic report_and_stop;
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : report_and_stop

  initial
  begin
    repeat (20000) @(posedge mclk);
    miscompares++;
    report_and_stop();
  end

  initial
  begin
    sum_m = 8'h00;
    general_pin_in = 7'h00;
    general_pin_data = 7'h00;
    repeat (6) @(posedge mclk);
    #1;
    rst = 1'b0;
    for (int i = 0; i < 7; i++)
      rd_chk(i);
    host_u.put(7'h7e, 8'hff);
    host_u.get(7'h7e, q);
    cmp_rd(q, 8'h00);
    repeat (3)
    begin
      general_pin_data = 7'($random(seed));
      general_pin_in = 7'($random(seed));
      for (int i = 0; i < 6; i++)
        wr_m(i, 8'($random(seed)));
      for (int i = 0; i < 6; i++)
        rd_chk(i);
      cmp_rd({stream_kind_select, controlled_stream_span}, mdl[0]);
      cmp_lvl(short_read_start, mdl[1][6:0]);
      cmp_lvl({4'h0, short_read_length}, {4'h0, mdl[2][2:0]});
      cmp_lvl(general_pin_oe, mdl[3][6:0] | {mdl[4][7], 6'h00});
      cmp_lvl(general_pin_out, mdl[4][7] ? {1'b1, general_pin_data[5:0]}
              : general_pin_data);
      cmp_lvl({gain_background_correction, checksum_enable,
               ready_release_after_checksum}, {mdl[4][3], mdl[5][4],
               mdl[5][2]});
      cmp_lvl(general_pin_sampled, general_pin_in);
    end
    for (int m = 0; m < 4; m++)
    begin
      wr_m(4, {2'b10, m[0], 5'h00});
      wr_m(5, {5'h02, m[1], 2'h0});
      wr_m(6, 8'($random(seed)));
      repeat (3)
      begin
        b = 8'($random(seed));
        host_u.ev(2, b);
        sum_m = sum_step(sum_m, b);
      end
      rd_chk(6);
      host_u.ev(0, 8'h00);
      cmp_lvl({4'h0, ready_n, general_pin_out[6], general_pin_oe[6]},
              7'h01);
      host_u.ev(1, 8'h00);
      if (!m[1] && !m[0])
        sum_m = 8'h00;
      cmp_lvl({6'h00, ready_n}, {6'h00, !m[1]});
      rd_chk(6);
      if (m[1] && !m[0])
        sum_m = 8'h00;
      cmp_lvl({6'h00, ready_n}, 7'h01);
      rd_chk(6);
    end
    wr_m(5, 8'h00);
    host_u.ev(2, 8'h5a);
    rd_chk(6);
    clk_en = 1'b0;
    host_u.put(adr[1], 8'h55);
    clk_en = 1'b1;
    rd_chk(1);
    report_and_stop();
  end
endmodule : test_spi_stream_crc_gpio_ctrl

bind ssc_regs ssc_regs_chk chk_u (.mclk, .rst, .clk_en, .reg_wr, .reg_rd,
  .reg_addr, .reg_wdata, .reg_rdata, .conv_done, .result_low_byte_read,
  .general_pin_out, .general_pin_oe, .ready_n, .stream_kind_select,
  .controlled_stream_span, .short_read_start, .short_read_length,
  .gain_background_correction, .checksum_enable,
  .ready_release_after_checksum);
